// *** dv/tpram_core_props.sv ***
/*
  Checker for tpram_core: read-port timing and register bus handshakes.
  Assumes tpram_pkg is compiled first and the bind below reaches u_dut.
*/
`timescale 1ns/1ns
`default_nettype none

module tpram_core_props
  import tpram_pkg::*;
(
  input wire logic                              i_core_clk,
  input wire logic                              i_rst,
  input wire logic                              i_read_clk,
  input wire logic                              i_ram_rst_n,
  input wire logic [tpram_pkg::TPRAM_DATA_W-1:0] o_read_data,
  input wire logic                              o_read_valid,
  input wire logic                              i_awvalid,
  input wire logic                              o_awready,
  input wire logic                              i_wvalid,
  input wire logic                              o_wready,
  input wire logic                              o_bvalid,
  input wire logic [1:0]                        o_bresp,
  input wire logic                              i_bready,
  input wire logic                              i_arvalid,
  input wire logic                              o_arready,
  input wire logic                              o_rvalid,
  input wire logic [tpram_pkg::TPRAM_AXI_DATA_W-1:0] o_rdata,
  input wire logic [1:0]                        o_rresp,
  input wire logic                              i_rready
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Five low samples cover the two-flop pin synchroniser
  chk_ram_rst_clr: assert property ((!i_ram_rst_n)[*5] |-> o_read_data == 18'h0 && !o_read_valid)
    else $error("read output not cleared under ram reset");
  // Either pin polarity counts, so compare levels rather than rises
  chk_rd_from_edge: assert property (o_read_valid |->
    ($past(i_read_clk, 3) != $past(i_read_clk, 4)) || ($past(i_read_clk, 4) != $past(i_read_clk, 5)))
    else $error("read valid without a read clock edge");
  chk_rd_pulse: assert property (o_read_valid |=> !o_read_valid)
    else $error("read valid longer than one cycle");

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before bready");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read response dropped before rready");
  chk_b_latency: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  chk_r_latency: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read response late");
  chk_b_reopen: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
    else $error("write channels not reopened");
  chk_r_reopen: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read address channel not reopened");
endmodule

bind tpram_core tpram_core_props u_props (.i_core_clk, .i_rst, .i_read_clk, .i_ram_rst_n, .o_read_data,
  .o_read_valid, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid,
  .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready);

`default_nettype wire

// *** dv/tpram_core_tb_top.sv ***
/*
  Self-checking bench for tpram_core: register bus tasks and pin-level
  accesses through the user model. Assumes the checker is bound separately.
*/
`timescale 1ns/1ns
`default_nettype none

module tpram_core_tb_top;
  import tpram_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ram_rst_n = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        wclk, wen, rclk, ren, awready, wready, bvalid, arready, rvalid, rd_valid;
  logic [8:0]  write_addr, read_addr;
  logic [17:0] wdat, rd_data;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_valid = 0;

  always #4 clk = ~clk;

  // Read valid pulses, tallied for one compare at the end
  always @(posedge clk) begin
    if (rd_valid === 1'h1) n_valid++;
  end

  tpram_core u_dut (.i_core_clk(clk), .i_rst(rst), .i_write_clk(wclk), .i_write_en(wen), .i_write_addr(write_addr),
    .i_write_data(wdat), .i_read_clk(rclk), .i_read_en(ren), .i_read_addr(read_addr), .i_ram_rst_n(ram_rst_n),
    .o_read_data(rd_data), .o_read_valid(rd_valid), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready));

  tpram_usr_model u_usr (.i_core_clk(clk), .o_write_clk(wclk), .o_write_en(wen), .o_write_addr(write_addr),
    .o_write_data(wdat), .o_read_clk(rclk), .o_read_en(ren), .o_read_addr(read_addr));

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Upper half is masked off where a 9-bit read drives it to zero
  task automatic cmp_rd(input logic [17:0] exp, input logic [17:0] mask);
    cmp("read_data", {14'h0, exp & mask}, {14'h0, rd_data & mask});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
    cmp("rdata", ed, rdata);
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    axi_rd(TPRAM_REG_CTRL, 32'h005, TPRAM_RESP_OKAY);
    axi_rd(8'h10, 32'h0, TPRAM_RESP_SLVERR);
    axi_wr(8'h10, 32'h1, TPRAM_RESP_SLVERR);
    axi_wr(TPRAM_REG_STATUS, 32'h7, TPRAM_RESP_OKAY);
    axi_rd(TPRAM_REG_STATUS, 32'h0, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h005, 18'h000a5, 1'h0, 9'h000);
    u_usr.acc(1'h1, 9'h004, 18'h0013c, 1'h1, 9'h005);
    cmp_rd(18'h000a5, 18'h001ff);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h004);
    cmp_rd(18'h0013c, 18'h001ff);
    axi_wr(TPRAM_REG_CTRL, 32'h00a, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h003, 18'h2aa55, 1'h1, 9'h002);
    cmp_rd({9'h0a5, 9'h13c}, 18'h3ffff);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h003);
    cmp_rd(18'h2aa55, 18'h3ffff);
    axi_wr(TPRAM_REG_CTRL, 32'h006, TPRAM_RESP_OKAY);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h007);
    cmp_rd(18'h00155, 18'h001ff);
    // Active-high enables, then a write and a read left inactive
    axi_wr(TPRAM_REG_CTRL, 32'h065, TPRAM_RESP_OKAY);
    u_usr.mode(1'h1, 1'h1, 1'h0, 1'h0);
    u_usr.acc(1'h1, 9'h009, 18'h00011, 1'h0, 9'h000);
    u_usr.mode(1'h0, 1'h1, 1'h0, 1'h0);
    u_usr.acc(1'h1, 9'h009, 18'h00022, 1'h0, 9'h000);
    u_usr.mode(1'h1, 1'h1, 1'h0, 1'h0);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h009);
    cmp_rd(18'h00011, 18'h001ff);
    u_usr.mode(1'h1, 1'h0, 1'h0, 1'h0);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h005);
    cmp_rd(18'h00011, 18'h001ff);
    // Pipelined reads lag by one read edge
    axi_wr(TPRAM_REG_CTRL, 32'h015, TPRAM_RESP_OKAY);
    u_usr.mode(1'h0, 1'h0, 1'h0, 1'h0);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h004);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h005);
    cmp_rd(18'h0013c, 18'h001ff);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h009);
    cmp_rd(18'h000a5, 18'h001ff);
    axi_wr(TPRAM_REG_CTRL, 32'h005, TPRAM_RESP_OKAY);
    ram_rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    cmp_rd(18'h0, 18'h3ffff);
    axi_rd(TPRAM_REG_STATUS, 32'h1, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h005, 18'h001ff, 1'h1, 9'h004);
    cmp_rd(18'h0, 18'h3ffff);
    ram_rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    // Reserved width codes on purpose: both ports must do nothing
    axi_wr(TPRAM_REG_CTRL, 32'h004, TPRAM_RESP_OKAY);
    axi_rd(TPRAM_REG_STATUS, 32'h2, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h005, 18'h00077, 1'h0, 9'h000);
    axi_wr(TPRAM_REG_CTRL, 32'h00f, TPRAM_RESP_OKAY);
    axi_rd(TPRAM_REG_STATUS, 32'h6, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h005, 18'h00077, 1'h1, 9'h004);
    cmp_rd(18'h0, 18'h3ffff);
    axi_wr(TPRAM_REG_CTRL, 32'h005, TPRAM_RESP_OKAY);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h005);
    cmp_rd(18'h000a5, 18'h001ff);
    // Inverted pin clocks: idle high, falling pin edge does the access
    u_usr.mode(1'h0, 1'h0, 1'h1, 1'h1);
    axi_wr(TPRAM_REG_CTRL, 32'h185, TPRAM_RESP_OKAY);
    u_usr.acc(1'h1, 9'h006, 18'h000c3, 1'h0, 9'h000);
    u_usr.acc(1'h0, 9'h000, 18'h0, 1'h1, 9'h006);
    cmp_rd(18'h000c3, 18'h001ff);
    // Byte lane 0 only: bit 8 of the control word must survive
    wstrb <= 4'h1;
    axi_wr(TPRAM_REG_CTRL, 32'h005, TPRAM_RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(TPRAM_REG_CTRL, 32'h105, TPRAM_RESP_OKAY);
    axi_rd(TPRAM_REG_WR_COUNT, 32'h5, TPRAM_RESP_OKAY);
    axi_rd(TPRAM_REG_RD_COUNT, 32'hb, TPRAM_RESP_OKAY);
    cmp("read_valid_count", 32'ha, n_valid);
    wrap_up();
  end

  // Tests need well under 2000 core cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule

`default_nettype wire

// *** dv/tpram_usr_model.sv ***
/*
  User logic driving the write and read pins of the two-port RAM.
  Assumes the core clock is free running; pins change just after its edges.
*/
`timescale 1ns/1ns
`default_nettype none

module tpram_usr_model (
  input  wire logic        i_core_clk,
  output logic             o_write_clk = 1'h0,
  output logic             o_write_en = 1'h1,
  output logic [8:0]       o_write_addr = 9'h0,
  output logic [17:0]      o_write_data = 18'h0,
  output logic             o_read_clk = 1'h0,
  output logic             o_read_en = 1'h1,
  output logic [8:0]       o_read_addr = 9'h0
);
  logic w_act = 1'h0;
  logic r_act = 1'h0;
  logic w_inv = 1'h0;
  logic r_inv = 1'h0;

  // Enable levels and idle clock levels
  task automatic mode(input logic wa, input logic ra, input logic wi, input logic ri);
    @(posedge i_core_clk);
    w_act <= wa;
    r_act <= ra;
    w_inv <= wi;
    r_inv <= ri;
    o_write_en <= ~wa;
    o_read_en <= ~ra;
    o_write_clk <= wi;
    o_read_clk <= ri;
  endtask

  // One pin cycle on both ports; slow enough for the pin synchronisers
  task automatic acc(input logic we, input logic [8:0] wa, input logic [17:0] wd,
                     input logic re, input logic [8:0] ra);
    @(posedge i_core_clk);
    o_write_en <= we ? w_act : ~w_act;
    o_write_addr <= wa;
    o_write_data <= wd;
    o_read_en <= re ? r_act : ~r_act;
    o_read_addr <= ra;
    repeat (3) @(posedge i_core_clk);
    o_write_clk <= ~w_inv;
    o_read_clk <= ~r_inv;
    repeat (3) @(posedge i_core_clk);
    // Released lines show the inverse, never a stale value
    o_write_en <= ~w_act;
    o_read_en <= ~r_act;
    o_write_addr <= ~wa;
    o_write_data <= ~wd;
    o_read_addr <= ~ra;
    o_write_clk <= w_inv;
    o_read_clk <= r_inv;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule

`default_nettype wire

// *** pkg/tpram_pkg.sv ***
/*
  Constants for the two-port RAM block: array geometry, width-select codes,
  register map of the AXI4-Lite slave and its field layout.
  Assumes a single 32-bit AXI4-Lite bus and one core clock.
*/
`default_nettype none

package tpram_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned TPRAM_ADDR_W  = 9;
  localparam int unsigned TPRAM_DATA_W  = 18;
  localparam int unsigned TPRAM_HALF_W  = 9;
  localparam int unsigned TPRAM_WORDS   = 512;
  localparam int unsigned TPRAM_WIDTH_W = 2;

  // Width-select codes; the other two codes are reserved
  localparam logic [1:0] TPRAM_WS_X9  = 2'h1;
  localparam logic [1:0] TPRAM_WS_X18 = 2'h2;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned TPRAM_AXI_ADDR_W = 8;
  localparam int unsigned TPRAM_AXI_DATA_W = 32;

  localparam logic [7:0] TPRAM_REG_CTRL     = 8'h00;
  localparam logic [7:0] TPRAM_REG_STATUS   = 8'h04;
  localparam logic [7:0] TPRAM_REG_WR_COUNT = 8'h08;
  localparam logic [7:0] TPRAM_REG_RD_COUNT = 8'h0c;

  localparam logic [1:0] TPRAM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TPRAM_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned TPRAM_CTRL_W        = 9;
  localparam int unsigned TPRAM_CTRL_WW_LSB   = 0;
  localparam int unsigned TPRAM_CTRL_RW_LSB   = 2;
  localparam int unsigned TPRAM_CTRL_PIPE     = 4;
  localparam int unsigned TPRAM_CTRL_WEN_HI   = 5;
  localparam int unsigned TPRAM_CTRL_REN_HI   = 6;
  localparam int unsigned TPRAM_CTRL_WCLK_INV = 7;
  localparam int unsigned TPRAM_CTRL_RCLK_INV = 8;
  localparam logic [8:0]  TPRAM_CTRL_RESET    = 9'h005;

  // Status register fields
  localparam int unsigned TPRAM_ST_W      = 3;
  localparam int unsigned TPRAM_ST_IN_RST = 0;
  localparam int unsigned TPRAM_ST_WW_BAD = 1;
  localparam int unsigned TPRAM_ST_RW_BAD = 2;

endpackage

`default_nettype wire

// *** src/tpram_core.sv ***
/*
  Two-port 512x9 / 256x18 RAM with separate write and read ports, an
  optional output pipeline stage and an AXI4-Lite control slave.
  Assumes the user-side port pins are asynchronous to i_core_clk and toggle
  slowly enough to be seen through two-flop synchronisers.
*/
`timescale 1ns/1ns
`default_nettype none

module tpram_core
  import tpram_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                                  i_core_clk,
  input  wire logic                                  i_rst,
  // User-side memory ports
  input  wire logic                                  i_write_clk,
  input  wire logic                                  i_write_en,
  input  wire logic [tpram_pkg::TPRAM_ADDR_W-1:0]    i_write_addr,
  input  wire logic [tpram_pkg::TPRAM_DATA_W-1:0]    i_write_data,
  input  wire logic                                  i_read_clk,
  input  wire logic                                  i_read_en,
  input  wire logic [tpram_pkg::TPRAM_ADDR_W-1:0]    i_read_addr,
  input  wire logic                                  i_ram_rst_n,
  output logic      [tpram_pkg::TPRAM_DATA_W-1:0]    o_read_data,
  output logic                                       o_read_valid,
  // AXI4-Lite slave
  input  wire logic [tpram_pkg::TPRAM_AXI_ADDR_W-1:0] i_awaddr,
  input  wire logic                                  i_awvalid,
  output logic                                       o_awready,
  input  wire logic [tpram_pkg::TPRAM_AXI_DATA_W-1:0] i_wdata,
  input  wire logic [3:0]                            i_wstrb,
  input  wire logic                                  i_wvalid,
  output logic                                       o_wready,
  output logic                                       o_bvalid,
  output logic      [1:0]                            o_bresp,
  input  wire logic                                  i_bready,
  input  wire logic [tpram_pkg::TPRAM_AXI_ADDR_W-1:0] i_araddr,
  input  wire logic                                  i_arvalid,
  output logic                                       o_arready,
  output logic                                       o_rvalid,
  output logic      [tpram_pkg::TPRAM_AXI_DATA_W-1:0] o_rdata,
  output logic      [1:0]                            o_rresp,
  input  wire logic                                  i_rready
);
  import tpram_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic width_ok(input logic [1:0] code);
    width_ok = (code == TPRAM_WS_X9) || (code == TPRAM_WS_X18);
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'h0};
  endfunction

  localparam int unsigned SYN_W = 2 * TPRAM_ADDR_W + TPRAM_DATA_W + 5;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [SYN_W-1:0]        port_raw;
  logic [SYN_W-1:0]        port_s1_r;
  logic [SYN_W-1:0]        port_s2_r;
  logic                    w_clk_s;
  logic                    w_en_s;
  logic [TPRAM_ADDR_W-1:0] w_addr_s;
  logic [TPRAM_DATA_W-1:0] w_data_s;
  logic                    r_clk_s;
  logic                    r_en_s;
  logic [TPRAM_ADDR_W-1:0] r_addr_s;
  logic                    ram_rst_n_s;

  logic [TPRAM_CTRL_W-1:0] ctrl_r;
  logic [1:0]              ww_sel;
  logic [1:0]              rw_sel;
  logic                    pipe_on;
  logic                    w_lvl;
  logic                    r_lvl;
  logic                    w_prev_r;
  logic                    r_prev_r;
  logic                    w_edge;
  logic                    r_edge;
  logic                    w_en_act;
  logic                    r_en_act;
  logic                    w_x18;
  logic                    r_x18;
  logic                    w_go;
  logic                    r_go;

  logic [TPRAM_HALF_W-1:0] mem [TPRAM_WORDS];
  logic [TPRAM_ADDR_W-1:0] w_idx [2];
  logic [TPRAM_HALF_W-1:0] w_half [2];
  logic [1:0]              w_lane_en;
  logic [TPRAM_ADDR_W-1:0] r_idx0;
  logic [TPRAM_ADDR_W-1:0] r_idx1;
  logic [TPRAM_DATA_W-1:0] rd_word;
  logic [TPRAM_DATA_W-1:0] stage_r;
  logic                    stage_vld_r;
  logic [CNT_W-1:0]        wr_cnt_r;
  logic [CNT_W-1:0]        rd_cnt_r;
  logic [TPRAM_ST_W-1:0]   status;

  logic [7:0]              aw_addr_r;
  logic [31:0]             w_data_r;
  logic [3:0]              w_strb_r;
  logic                    aw_full_r;
  logic                    w_full_r;
  logic                    aw_hs;
  logic                    w_hs;
  logic                    ar_hs;
  logic                    wr_do;
  logic                    aw_full_nxt;
  logic                    w_full_nxt;
  logic                    bvalid_nxt;
  logic                    rvalid_nxt;
  logic                    wr_ctrl;
  logic                    wr_hit;
  logic [TPRAM_CTRL_W-1:0] ctrl_nxt;
  logic [7:0]              rd_sel;
  logic                    rd_hit;
  logic [31:0]             rd_mux;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign port_raw = {i_write_clk, i_write_en, i_write_addr, i_write_data,
                     i_read_clk, i_read_en, i_read_addr, i_ram_rst_n};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      port_s1_r <= '0;
      port_s2_r <= '0;
    end else begin
      port_s1_r <= port_raw;
      port_s2_r <= port_s1_r;
    end
  end

  // Only the second stage is read; data and clocks see equal latency
  assign {w_clk_s, w_en_s, w_addr_s, w_data_s,
          r_clk_s, r_en_s, r_addr_s, ram_rst_n_s} = port_s2_r;

  // ----------------------------------------------------------------
  // Port clocking and enables
  // ----------------------------------------------------------------
  assign ww_sel  = ctrl_r[TPRAM_CTRL_WW_LSB +: TPRAM_WIDTH_W];
  assign rw_sel  = ctrl_r[TPRAM_CTRL_RW_LSB +: TPRAM_WIDTH_W];
  assign pipe_on = ctrl_r[TPRAM_CTRL_PIPE];

  // Inversion ahead of a rising-edge detector gives falling-edge use
  assign w_lvl  = w_clk_s ^ ctrl_r[TPRAM_CTRL_WCLK_INV];
  assign r_lvl  = r_clk_s ^ ctrl_r[TPRAM_CTRL_RCLK_INV];
  assign w_edge = w_lvl & ~w_prev_r;
  assign r_edge = r_lvl & ~r_prev_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      w_prev_r <= 1'b1;
      r_prev_r <= 1'b1;
    end else begin
      w_prev_r <= w_lvl;
      r_prev_r <= r_lvl;
    end
  end

  assign w_en_act = ctrl_r[TPRAM_CTRL_WEN_HI] ? w_en_s : ~w_en_s;
  assign r_en_act = ctrl_r[TPRAM_CTRL_REN_HI] ? r_en_s : ~r_en_s;
  assign w_x18    = (ww_sel == TPRAM_WS_X18);
  assign r_x18    = (rw_sel == TPRAM_WS_X18);

  // Reserved width codes block the port rather than guess a layout
  assign w_go = w_edge & w_en_act & ram_rst_n_s & width_ok(ww_sel);
  assign r_go = r_edge & r_en_act & ram_rst_n_s & width_ok(rw_sel);

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  // An 18-bit word k spans halves 2k and 2k+1; address MSB is ignored
  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign w_idx[l]     = w_x18 ? {w_addr_s[TPRAM_ADDR_W-2:0], 1'(l)} : w_addr_s;
    assign w_half[l]    = w_x18 ? w_data_s[l*TPRAM_HALF_W +: TPRAM_HALF_W]
                                : w_data_s[TPRAM_HALF_W-1:0];
    assign w_lane_en[l] = w_go & (w_x18 | (l == 0));
  end

  // Array has no reset so its contents survive both resets
  always_ff @(posedge i_core_clk) begin
    for (int l = 0; l < 2; l++) begin
      if (w_lane_en[l]) begin
        mem[w_idx[l]] <= w_half[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  assign r_idx0 = r_x18 ? {r_addr_s[TPRAM_ADDR_W-2:0], 1'b0} : r_addr_s;
  assign r_idx1 = {r_addr_s[TPRAM_ADDR_W-2:0], 1'b1};

  // Same-cycle collision reads the old word, which users must not trust
  assign rd_word = r_x18 ? {mem[r_idx1], mem[r_idx0]}
                         : {{TPRAM_HALF_W{1'b0}}, mem[r_idx0]};

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ram_rst_n_s) begin
      stage_r     <= '0;
      stage_vld_r <= 1'b0;
    end else if (r_edge) begin
      stage_vld_r <= r_go;
      if (r_go) begin
        stage_r <= rd_word;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ram_rst_n_s) begin
      o_read_data  <= '0;
      o_read_valid <= 1'b0;
    end else if (pipe_on) begin
      o_read_valid <= r_edge & stage_vld_r;
      if (r_edge) begin
        o_read_data <= stage_r;
      end
    end else begin
      o_read_valid <= r_go;
      if (r_go) begin
        o_read_data <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity counters
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_cnt_r <= '0;
      rd_cnt_r <= '0;
    end else begin
      if (w_go) begin
        wr_cnt_r <= wr_cnt_r + 1'b1;
      end
      if (r_go) begin
        rd_cnt_r <= rd_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign aw_hs       = i_awvalid & o_awready;
  assign w_hs        = i_wvalid & o_wready;
  assign wr_do       = aw_full_r & w_full_r & ~o_bvalid;
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_do;
  assign w_full_nxt  = (w_full_r | w_hs) & ~wr_do;
  assign bvalid_nxt  = (o_bvalid & ~i_bready) | wr_do;
  assign wr_ctrl     = wr_do & (word_addr(aw_addr_r) == TPRAM_REG_CTRL);
  assign wr_hit      = wr_ctrl
                     | (word_addr(aw_addr_r) == TPRAM_REG_STATUS)
                     | (word_addr(aw_addr_r) == TPRAM_REG_WR_COUNT)
                     | (word_addr(aw_addr_r) == TPRAM_REG_RD_COUNT);

  assign ctrl_nxt = {w_strb_r[1] ? w_data_r[8]   : ctrl_r[8],
                     w_strb_r[0] ? w_data_r[7:0] : ctrl_r[7:0]};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= TPRAM_RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      ctrl_r    <= TPRAM_CTRL_RESET;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      o_awready <= ~aw_full_nxt & ~bvalid_nxt;
      o_wready  <= ~w_full_nxt & ~bvalid_nxt;
      o_bvalid  <= bvalid_nxt;
      if (aw_hs) begin
        aw_addr_r <= i_awaddr;
      end
      if (w_hs) begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (wr_do) begin
        o_bresp <= wr_hit ? TPRAM_RESP_OKAY : TPRAM_RESP_SLVERR;
      end
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  assign status[TPRAM_ST_IN_RST] = ~ram_rst_n_s;
  assign status[TPRAM_ST_WW_BAD] = ~width_ok(ww_sel);
  assign status[TPRAM_ST_RW_BAD] = ~width_ok(rw_sel);

  assign ar_hs      = i_arvalid & o_arready;
  assign rvalid_nxt = (o_rvalid & ~i_rready) | ar_hs;
  assign rd_sel     = word_addr(i_araddr);
  assign rd_hit     = (rd_sel == TPRAM_REG_CTRL) | (rd_sel == TPRAM_REG_STATUS)
                    | (rd_sel == TPRAM_REG_WR_COUNT) | (rd_sel == TPRAM_REG_RD_COUNT);
  assign rd_mux     = (rd_sel == TPRAM_REG_CTRL)     ? 32'(ctrl_r)   :
                      (rd_sel == TPRAM_REG_STATUS)   ? 32'(status)   :
                      (rd_sel == TPRAM_REG_WR_COUNT) ? 32'(wr_cnt_r) :
                      (rd_sel == TPRAM_REG_RD_COUNT) ? 32'(rd_cnt_r) : 32'h0000_0000;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= TPRAM_RESP_OKAY;
    end else begin
      o_arready <= ~rvalid_nxt;
      o_rvalid  <= rvalid_nxt;
      if (ar_hs) begin
        o_rdata <= rd_mux;
        o_rresp <= rd_hit ? TPRAM_RESP_OKAY : TPRAM_RESP_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire
